/* src/prws_pkg.sv */
package prws_pkg;
    // ==========================================================
    // Register map
    localparam logic [7:0] PMC_OFFSET   = 8'h00;
    localparam logic [7:0] IRQ_STS_OFF  = 8'h04;
    localparam logic [7:0] IRQ_MASK_OFF = 8'h08;
    // ==========================================================
    // Field positions
    localparam int RST_BIT      = 4;
    localparam int LANW_BIT     = 3;
    localparam int ENW_BIT      = 2;
    localparam int CAUSE_HI     = 1;
    localparam int CAUSE_LO     = 0;
    localparam int SLEEP_LO     = 5;
    localparam int CLR_EN_BIT   = 8;
    localparam int CLR_STS_BIT  = 9;
    // ==========================================================
    // Reset values
    localparam logic [1:0] SLEEP_RST   = 2'h2;
    localparam logic       CLR_EN_RST  = 1'h1;
    localparam logic       CLR_STS_RST = 1'h0;
    // ==========================================================
    // Timing
    localparam int CLK_HZ        = 125000000;
    localparam int HOLD_US       = 2000;
    localparam int HOLD_CYCLES   = (CLK_HZ / 1000000) * HOLD_US;
    // ==========================================================
    // Interrupt bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_WAKE = 1;
    typedef enum logic [1:0] {
        PRWS_RUN  = 2'h0,
        PRWS_HOLD = 2'h1
    } prws_state_t;
endpackage

/* src/prws_top.sv */
// The Wishbone interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
// Behaviour
// - Writing one starts transceiver reset, hold 2 ms
// - Reset bit self-clears on release, resets zero
// - Writes to reset bit ignored while set
// - NAK all USB transfers during reset
// - LAN-wake enable, cleared on resume if enabled
// - Energy-detect enable, reset value zero
// - Energy enable cleared on resume if enabled
// - Two cause bits, set/cleared independently
// - Write one clears cause bit; reset zero
// - Cause 00 means no wake event
// - Upper cause bit: LAN wake or frame
// - Both cause bits may be set
// - Cause set only if armed before sleep
// - Cause setting ignores this register's enables
// - Resume clears upper cause if configured
// - Only remote-wake resumes clear enables
// - Sleep field selects sleep state 0..3
module prws_top #(
    parameter int HOLD_CYCLES = prws_pkg::HOLD_CYCLES
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        lan_wake_event_i,
    input  wire logic        energy_event_i,
    input  wire logic        armed_lan_i,
    input  wire logic        armed_energy_i,
    input  wire logic        resume_done_i,
    input  wire logic        resume_remote_i,
    output logic             transceiver_reset_o,
    output logic             usb_nak_o,
    output logic             lan_wake_enable_o,
    output logic             energy_wake_enable_o,
    output logic       [1:0] sleep_state_o,
    output logic             irq_o
);
    // ==========================================================
    // State
    typedef struct packed {
        prws_pkg::prws_state_t st;
        logic [31:0]           cnt;
        logic                  rst_req;
        logic                  lanw_en;
        logic                  enw_en;
        logic [1:0]            cause;
        logic [1:0]            sleep;
        logic                  clr_en;
        logic                  clr_sts;
        logic [1:0]            irq_sts;
        logic [1:0]            irq_mask;
        logic [31:0]           dat;
        logic                  ack;
        logic                  irq;
        logic [1:0]            ev_s1;
        logic [1:0]            ev_s2;
        logic [1:0]            ev_d;
        logic [3:0]            rs_s1;
        logic [3:0]            rs_s2;
        logic                  rdone_d;
    } prws_reg_t;

    prws_reg_t r;
    prws_reg_t next_r;

    // ==========================================================
    // Decode helper
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic [1:0]  rise;
    logic        rdone;
    logic [1:0]  wclr;

    always_comb begin
        next_r = r;
        wr     = wb_cyc_i && wb_stb_i && !r.ack && wb_we_i;
        rd     = wb_cyc_i && wb_stb_i && !r.ack && !wb_we_i;
        // Synchronise external events; stage one feeds stage two only
        next_r.ev_s1 = {lan_wake_event_i, energy_event_i};
        next_r.ev_s2 = r.ev_s1;
        next_r.ev_d  = r.ev_s2;
        next_r.rs_s1 = {armed_lan_i, armed_energy_i, resume_done_i, resume_remote_i};
        next_r.rs_s2 = r.rs_s1;
        next_r.rdone_d = r.rs_s2[1];
        rise  = r.ev_s2 & ~r.ev_d;
        rdone = r.rs_s2[1] && !r.rdone_d;
        wclr  = 2'h0;

        // ======================================================
        // Transceiver reset sequencer
        case (r.st)
            prws_pkg::PRWS_RUN: begin
                if (wr && hit(wb_adr_i, prws_pkg::PMC_OFFSET) && wb_sel_i[0]
                    && wb_dat_i[prws_pkg::RST_BIT]) begin
                    next_r.st      = prws_pkg::PRWS_HOLD;
                    next_r.rst_req = 1'b1;
                    next_r.cnt     = 32'(HOLD_CYCLES - 1);
                end
            end
            prws_pkg::PRWS_HOLD: begin
                if (r.cnt == 32'h0) begin
                    next_r.st      = prws_pkg::PRWS_RUN;
                    next_r.rst_req = 1'b0;
                    next_r.irq_sts[prws_pkg::IRQ_DONE] = 1'b1;
                end else begin
                    next_r.cnt = r.cnt - 32'h1;
                end
            end
            default: begin
                next_r.st      = prws_pkg::PRWS_RUN;
                next_r.rst_req = 1'b0;
            end
        endcase

        // ======================================================
        // Register writes
        if (wr && hit(wb_adr_i, prws_pkg::PMC_OFFSET)) begin
            if (wb_sel_i[0]) begin
                next_r.lanw_en = wb_dat_i[prws_pkg::LANW_BIT];
                next_r.enw_en  = wb_dat_i[prws_pkg::ENW_BIT];
                next_r.sleep   = wb_dat_i[prws_pkg::SLEEP_LO +: 2];
                wclr = wb_dat_i[1:0];
            end
            if (wb_sel_i[1]) begin
                next_r.clr_en  = wb_dat_i[prws_pkg::CLR_EN_BIT];
                next_r.clr_sts = wb_dat_i[prws_pkg::CLR_STS_BIT];
            end
        end
        if (wr && hit(wb_adr_i, prws_pkg::IRQ_MASK_OFF) && wb_sel_i[0]) begin
            next_r.irq_mask = wb_dat_i[1:0];
        end
        if (wr && hit(wb_adr_i, prws_pkg::IRQ_STS_OFF) && wb_sel_i[0]) begin
            next_r.irq_sts = next_r.irq_sts & ~wb_dat_i[1:0];
        end
        // Completion in the same cycle as a clear must not be lost
        if (r.st == prws_pkg::PRWS_HOLD && r.cnt == 32'h0) begin
            next_r.irq_sts[prws_pkg::IRQ_DONE] = 1'b1;
        end

        // ======================================================
        // Wake cause: clears first, events win after
        next_r.cause = r.cause & ~wclr;
        if (rdone && r.clr_sts) begin
            next_r.cause[prws_pkg::CAUSE_HI] = 1'b0;
        end
        if (rdone && r.clr_en && r.rs_s2[0]) begin
            next_r.lanw_en = 1'b0;
            next_r.enw_en  = 1'b0;
        end
        // Armed levels latched by the sleep logic, not this register's enables
        if (rise[1] && r.rs_s2[3]) begin
            next_r.cause[prws_pkg::CAUSE_HI] = 1'b1;
        end
        if (rise[0] && r.rs_s2[2]) begin
            next_r.cause[prws_pkg::CAUSE_LO] = 1'b1;
        end
        if ((rise[1] && r.rs_s2[3]) || (rise[0] && r.rs_s2[2])) begin
            next_r.irq_sts[prws_pkg::IRQ_WAKE] = 1'b1;
        end

        // ======================================================
        // Bus answer: one-cycle ack, then drop
        next_r.ack = wb_cyc_i && wb_stb_i && !r.ack;
        rdata = 32'h0;
        if (hit(wb_adr_i, prws_pkg::PMC_OFFSET)) begin
            rdata[prws_pkg::RST_BIT]        = r.rst_req;
            rdata[prws_pkg::LANW_BIT]       = r.lanw_en;
            rdata[prws_pkg::ENW_BIT]        = r.enw_en;
            rdata[1:0]                      = r.cause;
            rdata[prws_pkg::SLEEP_LO +: 2]  = r.sleep;
            rdata[prws_pkg::CLR_EN_BIT]     = r.clr_en;
            rdata[prws_pkg::CLR_STS_BIT]    = r.clr_sts;
        end else if (hit(wb_adr_i, prws_pkg::IRQ_STS_OFF)) begin
            rdata[1:0] = r.irq_sts;
        end else if (hit(wb_adr_i, prws_pkg::IRQ_MASK_OFF)) begin
            rdata[1:0] = r.irq_mask;
        end
        next_r.dat = rd ? rdata : 32'h0;
        next_r.irq = |(next_r.irq_sts & next_r.irq_mask);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r         <= '0;
            r.st      <= prws_pkg::PRWS_RUN;
            r.sleep   <= prws_pkg::SLEEP_RST;
            r.clr_en  <= prws_pkg::CLR_EN_RST;
            r.clr_sts <= prws_pkg::CLR_STS_RST;
        end else if (ce_i) begin
            r <= next_r;
        end
    end

    // ==========================================================
    // Outputs, all flopped
    assign wb_dat_o             = r.dat;
    assign wb_ack_o             = r.ack;
    assign transceiver_reset_o  = r.rst_req;
    assign usb_nak_o            = r.rst_req;
    assign lan_wake_enable_o    = r.lanw_en;
    assign energy_wake_enable_o = r.enw_en;
    assign sleep_state_o        = r.sleep;
    assign irq_o                = r.irq;
endmodule

/* tb/prws_top_sva.sv */
`timescale 1ns/1ps
module prws_sva #(
    parameter int HOLD_CYCLES = 20
) (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        transceiver_reset_o,
    input wire logic        usb_nak_o,
    input wire logic        lan_wake_enable_o,
    input wire logic [1:0]  sleep_state_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ==========================================
    // Hold counter, a repetition would be too long
    int cnt;
    always_ff @(posedge clk_i) begin
        cnt <= (transceiver_reset_o && !rst_i) ? cnt + 1 : 0;
    end
    // ==========================================
    // Properties
    a_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("data without ack");
    a_nak_tracks: assert property (usb_nak_o == transceiver_reset_o)
        else $error("nak differs");
    a_hold_len: assert property ($fell(transceiver_reset_o) |-> cnt == HOLD_CYCLES)
        else $error("hold length wrong");
    a_reset_start: assert property (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o
        && wb_adr_i == 8'h00 && wb_sel_i[0] && wb_dat_i[4] |-> ##[1:2] transceiver_reset_o)
        else $error("reset not started");
    a_sleep_reset: assert property (disable iff (1'b0)
        rst_i |=> sleep_state_o == 2'h2 && !transceiver_reset_o)
        else $error("reset values wrong");
    a_en_by_write: assert property ($rose(lan_wake_enable_o) |->
        $past(wb_cyc_i && wb_stb_i && wb_we_i))
        else $error("enable rose alone");
endmodule
bind prws_top prws_sva #(.HOLD_CYCLES(HOLD_CYCLES)) chk (.*);

/* tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
    localparam int HOLD = 20;
    logic        clk_i = 0, rst_i = 1, ce_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic        wb_ack_o, transceiver_reset_o, usb_nak_o, irq_o;
    logic        lan_wake_enable_o, energy_wake_enable_o, armed_lan_i = 0;
    logic        armed_energy_i = 0, resume_remote_i = 0;
    logic [1:0]  sleep_state_o;
    logic [2:0]  pls = 3'h0;
    wire         lan_wake_event_i = pls[0];
    wire         energy_event_i = pls[1];
    wire         resume_done_i = pls[2];
    int          errors = 0, n_tests = 0, n;
    prws_top #(.HOLD_CYCLES(HOLD)) uut (.*);
    initial begin
        forever #4 clk_i = ~clk_i;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    // Holds the request until ack is sampled
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'h0;
    endtask
    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask
    task automatic pulse(input logic [2:0] m);
        @(posedge clk_i);
        pls <= m;
        repeat (4) @(posedge clk_i);
        pls <= 3'h0;
        repeat (5) @(posedge clk_i);
    endtask
    task automatic final_report;
        $display("errors %0d n_tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        #200000;
        errors++;
        final_report;
    end
    // ==========================================
    // Tests
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 0;
        rdc("ctrl", 8'h00, 32'h140);
        chk("sleep", 32'h2, 32'(sleep_state_o));
        bus(1'b1, 8'h00, 32'h150);
        n = 0;
        // Sampled mid-cycle; the ack cycle itself is already spent
        repeat (HOLD + 10) begin
            @(negedge clk_i);
            n += int'(transceiver_reset_o === 1'b1);
        end
        chk("hold", HOLD - 1, n);
        rdc("ctrl", 8'h00, 32'h140);
        rdc("sts", 8'h04, 32'h1);
        chk("irq", 32'h0, 32'(irq_o));
        bus(1'b1, 8'h08, 32'h3);
        chk("irq_m", 32'h1, 32'(irq_o));
        bus(1'b1, 8'h08, 32'h0);
        bus(1'b1, 8'h04, 32'h1);
        rdc("sts", 8'h04, 32'h0);
        bus(1'b1, 8'h00, 32'h150);
        bus(1'b1, 8'h00, 32'h140);
        rdc("busy", 8'h00, 32'h150);
        chk("nak", 32'h1, 32'(usb_nak_o));
        repeat (HOLD + 5) @(posedge clk_i);
        bus(1'b1, 8'h00, 32'h14C);
        chk("ens", 32'h3, 32'({lan_wake_enable_o, energy_wake_enable_o}));
        pulse(3'h4);
        chk("host", 32'h3, 32'({lan_wake_enable_o, energy_wake_enable_o}));
        resume_remote_i <= 1;
        pulse(3'h4);
        chk("rmt", 32'h0, 32'({lan_wake_enable_o, energy_wake_enable_o}));
        resume_remote_i <= 0;
        armed_lan_i <= 1;
        pulse(3'h3);
        rdc("lan", 8'h00, 32'h142);
        armed_energy_i <= 1;
        pulse(3'h2);
        rdc("both", 8'h00, 32'h143);
        bus(1'b1, 8'h00, 32'h142);
        rdc("w1c", 8'h00, 32'h141);
        bus(1'b1, 8'h00, 32'h340);
        pulse(3'h1);
        rdc("set", 8'h00, 32'h343);
        pulse(3'h4);
        rdc("rsm", 8'h00, 32'h341);
        bus(1'b1, 8'h0C, 32'hFFFFFFFF);
        rdc("hole", 8'h0C, 32'h0);
        rst_i <= 1;
        repeat (2) @(posedge clk_i);
        rst_i <= 0;
        rdc("rst2", 8'h00, 32'h140);
        final_report;
    end
endmodule
